// File: hw/dcc_top.sv
// control and status logic around two analog comparators, apb slave
`timescale 1ns/1ps
module dcc_top
  import dcc_pkg::*;
(
  input wire logic clk, // 125 mhz instruction clock
  input wire logic nrst, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic [1:0] cmp_raw, // analog comparator outputs, async
  input wire logic [7:0] port_a_in, // port a pin levels, async
  input wire logic sleeping, // device is in sleep
  output logic [7:0] port_a_out, // port a output levels
  output logic [7:0] port_a_oe_n, // port a output enables, low drives
  output logic [2:0] cmp_mode, // mode to the analog block
  output logic cmp_use_ref, // reference on positive inputs
  output logic [1:0] cmp_neg_sel, // negative input pair select
  output logic cmp_active, // comparators powered
  output logic irq, // interrupt request
  output logic wake // wake request out of sleep
);
  import dcc_pkg::*;

  // control fields of comparator_control_reg
  logic [5:0] cmp_ctrl_r; // mode, swap, inverts
  logic [7:0] int_ctrl_r; // interrupt_control_reg
  logic [7:0] pflag2_r; // periph_flag_reg_two
  logic [7:0] pen2_r; // periph_enable_reg_two
  logic [7:0] ppri2_r; // priorities, stored only
  logic [7:0] porta_dir_r; // port_a_direction, 1 = input
  logic [7:0] porta_lat_r; // port a output latch
  logic [3:0] analog_cfg_r; // analog_pin_config
  logic [1:0] captured_r; // last captured result copy
  dcc_state_t state_r; // mismatch tracker
  dcc_state_t state_nxt;
  logic [1:0] res_sync; // synchronised adjusted results
  logic [7:0] pin_sync; // synchronised pin levels
  logic [1:0] res_adj; // unsynchronised adjusted results
  logic use_ref, active, pin_out;
  logic [1:0] neg_sel;
  logic [7:0] analog_mask; // 1 = pin is analog
  logic [7:0] port_read; // port data as read
  logic acc_phase; // apb access cycle
  logic wr_en, rd_en;
  logic mapped; // address hits a register
  logic cmp_ctrl_hit; // read or write of the control register
  logic mismatch; // live results differ from capture
  logic [7:0] cmp_ctrl_view; // readable control register
  logic [31:0] rd_mux;

  // apb strobes; a write lands in the single access cycle, and the
  // slave never stretches that phase, so no wait logic is needed
  assign acc_phase = psel & penable;
  assign wr_en = acc_phase & pwrite;
  assign rd_en = acc_phase & ~pwrite;

  // decode of the mapped offsets
  // the mapped table only feeds pslverr; reads decode on their own
  always_comb
  begin
    unique case (paddr)
      OFF_CMP_CTRL, OFF_INT_CTRL, OFF_PFLAG2, OFF_PEN2, OFF_PPRI2,
      OFF_PORTA_DIR, OFF_PORTA_LAT, OFF_PORTA_DATA, OFF_CONV_CFG1,
      OFF_CMP_RAW: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign cmp_ctrl_hit = acc_phase & (paddr == OFF_CMP_CTRL);

  // mode decode and polarity
  dcc_pin_mux u_mux (
    .mode(cmp_ctrl_r[MODE_LSB +: 3]),
    .swap(cmp_ctrl_r[SWAP_BIT]),
    .inv({cmp_ctrl_r[INV2_BIT], cmp_ctrl_r[INV1_BIT]}),
    .raw(cmp_raw),
    .res(res_adj),
    .use_ref(use_ref),
    .neg_sel(neg_sel),
    .active(active),
    .pin_out(pin_out)
  );

  // a result change counts only once the late stages agree
  // sample each cycle
  dcc_sync3 #(.WIDTH(2)) u_res_sync (
    .clk(clk),
    .nrst(nrst),
    .din(res_adj),
    .dout(res_sync)
  );

  // pin levels come from outside the clock domain
  dcc_sync3 #(.WIDTH(8)) u_pin_sync (
    .clk(clk),
    .nrst(nrst),
    .din(port_a_in),
    .dout(pin_sync)
  );

  // off comparators never count as changed, so turning the pair
  // off cannot raise a stray flag on its own
  // off comparators read low
  assign mismatch = active & (res_sync != captured_r);

  // comparator control register; results never written
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      cmp_ctrl_r <= CMP_CTRL_RST;
    else if (wr_en && paddr == OFF_CMP_CTRL)
      cmp_ctrl_r <= pwdata[5:0];
  end

  // capture copy of the results
  // powering down clears the copy; the next power-up then shows as
  // a change, which is why software masks the interrupt around it
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      captured_r <= 2'b00;
    else if (cmp_ctrl_hit)
      captured_r <= active ? res_sync : 2'b00;
    else if (!active)
      captured_r <= 2'b00;
  end

  // mismatch tracker, one-hot; the flag logic watches the next state
  // so a fresh mismatch sets the flag one edge after the results move
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      // idle until the synchronised results leave the capture
      DCC_ST_MATCH:
        if (mismatch)
          state_nxt = DCC_ST_MISMATCH;
      // stays here until the results match the capture again, as after a recapture
      DCC_ST_MISMATCH:
        if (!mismatch)
          state_nxt = DCC_ST_MATCH;
      // a lost one-hot code falls back to a fresh comparison
      default:
        state_nxt = mismatch ? DCC_ST_MISMATCH : DCC_ST_MATCH;
    endcase
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      state_r <= DCC_ST_MATCH;
    else
      state_r <= state_nxt;
  end

  // a control access and a flag write never share a cycle, as they
  // decode different offsets, so only the recapture can mask a set
  // recapture in same cycle as change can hide it
  // peripheral flag register; hardware set beats software clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pflag2_r <= 8'h00;
    else
    begin
      if (wr_en && paddr == OFF_PFLAG2)
        pflag2_r <= pwdata[7:0];
      if (state_nxt == DCC_ST_MISMATCH && !cmp_ctrl_hit)
        pflag2_r[CHG_BIT] <= 1'b1;
    end
  end

  // enable registers
  // priority bits are stored for software only; this block raises
  // a single request line whatever they hold
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      int_ctrl_r <= 8'h00;
      pen2_r <= 8'h00;
      ppri2_r <= 8'h00;
    end
    else if (wr_en)
    begin
      if (paddr == OFF_INT_CTRL)
        int_ctrl_r <= pwdata[7:0];
      if (paddr == OFF_PEN2)
        pen2_r <= pwdata[7:0];
      if (paddr == OFF_PPRI2)
        ppri2_r <= pwdata[7:0];
    end
  end

  // port direction, latch and analog configuration
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      porta_dir_r <= PORTA_DIR_RST;
      porta_lat_r <= 8'h00;
      analog_cfg_r <= ANALOG_CFG_RST;
    end
    else if (wr_en)
    begin
      if (paddr == OFF_PORTA_DIR)
        porta_dir_r <= pwdata[7:0];
      if (paddr == OFF_PORTA_LAT)
        porta_lat_r <= pwdata[7:0];
      if (paddr == OFF_CONV_CFG1)
        analog_cfg_r <= pwdata[3:0];
    end
  end

  // configs up to b keep all four low pins analog; codes c to f free them
  // one by one from the top, a simple stand-in for the full table
  assign analog_mask = {4'h0,
    (analog_cfg_r <= 4'hb), (analog_cfg_r <= 4'hc),
    (analog_cfg_r <= 4'hd), (analog_cfg_r <= 4'he)};
  assign port_read = pin_sync & ~analog_mask;

  assign cmp_ctrl_view = {res_sync[1] & active, res_sync[0] & active,
    cmp_ctrl_r};

  // read mux
  // unmapped offsets read zero and raise pslverr instead
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFF_CMP_CTRL: rd_mux[7:0] = cmp_ctrl_view;
      OFF_INT_CTRL: rd_mux[7:0] = int_ctrl_r;
      OFF_PFLAG2: rd_mux[7:0] = pflag2_r;
      OFF_PEN2: rd_mux[7:0] = pen2_r;
      OFF_PPRI2: rd_mux[7:0] = ppri2_r;
      OFF_PORTA_DIR: rd_mux[7:0] = porta_dir_r;
      OFF_PORTA_LAT: rd_mux[7:0] = porta_lat_r;
      OFF_PORTA_DATA: rd_mux[7:0] = port_read;
      OFF_CONV_CFG1: rd_mux[3:0] = analog_cfg_r;
      OFF_CMP_RAW: rd_mux[1:0] = cmp_raw & {2{active}};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // apb answer registered: ready in the first cycle of the access phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // port pins; comparator results replace latch bits four and five
  // the pin path skips the synchroniser on purpose: the pins show the
  // live result, at the cost of possible glitches near a threshold
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      port_a_out <= 8'h00;
      port_a_oe_n <= 8'hff;
    end
    else
    begin
      port_a_oe_n <= porta_dir_r;
      port_a_out <= pin_out ? {porta_lat_r[7:6], res_adj, porta_lat_r[3:0]}
        : porta_lat_r;
    end
  end

  // status toward the analog block and the core
  // wake ignores the two global enables: an enabled change ends sleep
  // even while the core keeps its interrupts masked
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmp_mode <= MODE_OFF;
      cmp_use_ref <= 1'b0;
      cmp_neg_sel <= 2'b00;
      cmp_active <= 1'b0;
      irq <= 1'b0;
      wake <= 1'b0;
    end
    else
    begin
      cmp_mode <= cmp_ctrl_r[MODE_LSB +: 3];
      cmp_use_ref <= use_ref;
      cmp_neg_sel <= neg_sel;
      cmp_active <= active;
      irq <= pflag2_r[CHG_BIT] & pen2_r[CHG_BIT]
        & int_ctrl_r[PERIPH_EN_BIT] & int_ctrl_r[GLOBAL_EN_BIT];
      wake <= sleeping & pflag2_r[CHG_BIT] & pen2_r[CHG_BIT];
    end
  end
endmodule

// File: hw/dcc_pkg.sv
// shared constants for the dual comparator control block
package dcc_pkg;
  // register byte offsets on the apb bus
  localparam logic [7:0] OFF_CMP_CTRL = 8'h00;
  localparam logic [7:0] OFF_INT_CTRL = 8'h04;
  localparam logic [7:0] OFF_PFLAG2 = 8'h08;
  localparam logic [7:0] OFF_PEN2 = 8'h0c;
  localparam logic [7:0] OFF_PPRI2 = 8'h10;
  localparam logic [7:0] OFF_PORTA_DIR = 8'h14;
  localparam logic [7:0] OFF_PORTA_LAT = 8'h18;
  localparam logic [7:0] OFF_PORTA_DATA = 8'h1c;
  localparam logic [7:0] OFF_CONV_CFG1 = 8'h20;
  localparam logic [7:0] OFF_CMP_RAW = 8'h24;
  // comparator control field positions
  localparam int MODE_LSB = 0;
  localparam int SWAP_BIT = 3;
  localparam int INV1_BIT = 4;
  localparam int INV2_BIT = 5;
  localparam int RES1_BIT = 6;
  localparam int RES2_BIT = 7;
  // flag, enable and interrupt control bit positions
  localparam int CHG_BIT = 6;
  localparam int PERIPH_EN_BIT = 6;
  localparam int GLOBAL_EN_BIT = 7;
  // reset values
  localparam logic [5:0] CMP_CTRL_RST = 6'h07;
  localparam logic [7:0] PORTA_DIR_RST = 8'hff;
  localparam logic [3:0] ANALOG_CFG_RST = 4'h0;
  // modes of the three-bit mode field
  localparam logic [2:0] MODE_MUX4 = 3'h6;
  localparam logic [2:0] MODE_OFF = 3'h7;
  localparam logic [2:0] MODE_PINOUT_A = 3'h3;
  localparam logic [2:0] MODE_PINOUT_B = 3'h5;
  // mismatch tracker state
  typedef enum logic [1:0] {
    DCC_ST_MATCH = 2'b01,
    DCC_ST_MISMATCH = 2'b10
  } dcc_state_t;
endpackage

// File: hw/dcc_sync3.sv
// three-flop synchroniser; a change counts once stages two and three agree
`timescale 1ns/1ps
module dcc_sync3 #(
  parameter int WIDTH = 2
) (
  input wire logic clk, // system clock
  input wire logic nrst, // async reset, active low
  input wire logic [WIDTH-1:0] din, // asynchronous input
  output logic [WIDTH-1:0] dout // filtered output
);
  logic [WIDTH-1:0] s1_r; // first stage, read only by s2_r
  logic [WIDTH-1:0] s2_r; // second stage
  logic [WIDTH-1:0] s3_r; // third stage

  // shift chain
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept per bit only when the two late stages agree
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          dout[i] <= 1'b0;
        else if (s2_r[i] == s3_r[i])
          dout[i] <= s3_r[i];
      end
    end
  endgenerate
endmodule

// File: hw/dcc_pin_mux.sv
// per-mode input routing and result polarity for the two comparators
`timescale 1ns/1ps
module dcc_pin_mux
  import dcc_pkg::*;
(
  input wire logic [2:0] mode, // config_mode_field
  input wire logic swap, // input_swap_bit
  input wire logic [1:0] inv, // invert bits, bit0 first comparator
  input wire logic [1:0] raw, // raw comparator results
  output logic [1:0] res, // polarity-adjusted results
  output logic use_ref, // internal reference on positive inputs
  output logic [1:0] neg_sel, // 0: pins 0/1, 1: pins 3/2
  output logic active, // comparators powered
  output logic pin_out // results routed to port pins
);
  assign res = raw ^ inv;
  assign use_ref = (mode == MODE_MUX4);
  assign neg_sel = (mode == MODE_MUX4) ? {2{swap}} : 2'b00;
  assign active = (mode != MODE_OFF);
  assign pin_out = (mode == MODE_PINOUT_A) || (mode == MODE_PINOUT_B);
endmodule

// File: verif/dcc_analog_model.sv
// behavioural analog comparator pair driving the raw result inputs
`timescale 1ns/1ps
module dcc_analog_model (
  input wire logic [15:0] vin_pos, // plus levels, one byte each
  input wire logic [15:0] vin_neg, // minus levels, one byte each
  input wire logic active, // comparators powered
  output logic [1:0] cmp_raw // raw results, bit0 first
);
  // unpowered comparators sit low, never floating
  assign cmp_raw[0] = active && vin_pos[7:0] > vin_neg[7:0];
  assign cmp_raw[1] = active && vin_pos[15:8] > vin_neg[15:8];
endmodule

// File: verif/dcc_top_monitor.sv
// port-level assertions for the comparator control block
`timescale 1ns/1ps
module dcc_top_monitor
  import dcc_pkg::*;
(
  input wire logic clk, // clock
  input wire logic nrst, // reset
  input wire logic psel, // apb
  input wire logic penable, // apb
  input wire logic pwrite, // apb
  input wire logic [7:0] paddr, // apb
  input wire logic [31:0] prdata, // apb
  input wire logic pready, // apb
  input wire logic pslverr, // apb
  input wire logic [2:0] cmp_mode, // mode out
  input wire logic cmp_use_ref, // ref select
  input wire logic [1:0] cmp_neg_sel, // negative pair select
  input wire logic cmp_active, // powered
  input wire logic irq // request
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);
  chk_ready_after_setup: assert property (
    psel && !penable |=> pready) else $error("no ready after setup");
  chk_ready_one_cycle: assert property (
    pready |=> !pready) else $error("ready held too long");
  chk_err_zero_data: assert property (
    pslverr |-> pready && prdata == 32'h0) else $error("bad error read");
  chk_upper_bits_zero: assert property (
    pready |-> prdata[31:8] == 24'h0) else $error("upper bits set");
  chk_reset_mode_off: assert property (
    $rose(nrst) |-> cmp_mode == MODE_OFF && !cmp_active)
    else $error("mode not off after reset");
  chk_ref_only_mux4: assert property (
    cmp_use_ref |-> cmp_mode == MODE_MUX4) else $error("ref in wrong mode");
  chk_swap_only_mux4: assert property (
    cmp_neg_sel != 2'b00 |-> cmp_mode == MODE_MUX4)
    else $error("swap in wrong mode");
  chk_active_vs_mode: assert property (
    cmp_active == (cmp_mode != MODE_OFF)) else $error("power mismatch");
  // results read low while both comparators are off
  chk_off_reads_zero: assert property (
    pready && !pwrite && paddr == OFF_CMP_CTRL && cmp_mode == MODE_OFF
    |-> prdata[7:6] == 2'b00) else $error("result while off");
  cover property (pslverr);
  cover property (cmp_use_ref);
  cover property (irq);
  cover property (cmp_neg_sel == 2'b11);
endmodule
bind dcc_top dcc_top_monitor u_dcc_top_monitor (.*);

// File: verif/dcc_top_test.sv
// self-checking bench for the comparator control block
`timescale 1ns/1ps
module dcc_top_test;
  import dcc_pkg::*;
  logic clk, nrst, psel, penable, pwrite, sleeping, se;
  logic pready, pslverr, cmp_use_ref, cmp_active, irq, wake;
  logic [7:0] paddr, port_a_in, port_a_out, port_a_oe_n;
  logic [31:0] pwdata, prdata, q;
  logic [2:0] cmp_mode;
  logic [1:0] cmp_neg_sel, cmp_raw;
  logic [15:0] vin_pos, vin_neg; // analog levels into the model
  int num_errors = 0;
  int total_checks = 0;
  dcc_top u_dcc_top (
    .clk(clk),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cmp_raw(cmp_raw),
    .port_a_in(port_a_in),
    .sleeping(sleeping),
    .port_a_out(port_a_out),
    .port_a_oe_n(port_a_oe_n),
    .cmp_mode(cmp_mode),
    .cmp_use_ref(cmp_use_ref),
    .cmp_neg_sel(cmp_neg_sel),
    .cmp_active(cmp_active),
    .irq(irq),
    .wake(wake)
  );
  dcc_analog_model u_dcc_analog_model (.vin_pos, .vin_neg,
    .active(cmp_active), .cmp_raw);
  // free-running 125 mhz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; waits a bounded time for ready
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      // a slave that never answers counts once and ends the run
      num_errors++;
      conclude();
    end
    else
    begin
      q = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // idle edge so the next setup never lands in this time step
      @(posedge clk);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, {24'h0, d});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, {24'h0, e});
  endtask
  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sleeping = 1'b0;
    port_a_in = 8'hff;
    vin_pos = 16'h0080; // first comparator high, second low
    vin_neg = 16'h4040;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(OFF_CMP_CTRL, 8'h07);
    rd(OFF_PORTA_DIR, 8'hff);
    rd(OFF_PORTA_DATA, 8'hf0);
    wr(OFF_CMP_CTRL, 8'hc7);
    rd(OFF_CMP_CTRL, 8'h07);
    $display("test reset done");
    // interrupt enables stay clear while modes change
    for (int m = 0; m < 8; m++)
    begin
      wr(OFF_CMP_CTRL, 8'(m));
      xfer(1'b0, OFF_CMP_CTRL, 32'h0);
      chk(q & 32'h3f, 32'(m));
      chk(32'(cmp_use_ref), 32'(m == 6));
    end
    // registered selects settle one edge after the write lands
    wr(OFF_CMP_CTRL, 8'h0e);
    @(posedge clk);
    chk(32'(cmp_neg_sel), 32'h3);
    wr(OFF_CMP_CTRL, 8'h0b);
    @(posedge clk);
    chk(32'(cmp_neg_sel), 32'h0);
    $display("test modes done");
    wr(OFF_CMP_CTRL, 8'h02);
    repeat (8) @(posedge clk);
    rd(OFF_CMP_CTRL, 8'h42);
    wr(OFF_CMP_CTRL, 8'h32);
    repeat (8) @(posedge clk);
    rd(OFF_CMP_CTRL, 8'hb2);
    wr(OFF_CMP_CTRL, 8'h02);
    repeat (8) @(posedge clk);
    rd(OFF_CMP_CTRL, 8'h42);
    wr(OFF_PFLAG2, 8'h00);
    rd(OFF_PFLAG2, 8'h00);
    $display("test results done");
    vin_pos <= 16'h8080;
    repeat (8) @(posedge clk);
    rd(OFF_PFLAG2, 8'h40);
    // clearing while the mismatch lasts must not stick
    wr(OFF_PFLAG2, 8'h00);
    rd(OFF_PFLAG2, 8'h40);
    rd(OFF_CMP_CTRL, 8'hc2);
    wr(OFF_PFLAG2, 8'h00);
    rd(OFF_PFLAG2, 8'h00);
    $display("test change done");
    wr(OFF_PFLAG2, 8'h40);
    rd(OFF_PFLAG2, 8'h40);
    wr(OFF_PEN2, 8'h40);
    wr(OFF_INT_CTRL, 8'h40);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0);
    wr(OFF_INT_CTRL, 8'hc0);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1);
    chk(32'(wake), 32'h0);
    sleeping <= 1'b1;
    repeat (3) @(posedge clk);
    chk(32'(wake), 32'h1);
    sleeping <= 1'b0;
    rd(OFF_CMP_CTRL, 8'hc2);
    wr(OFF_INT_CTRL, 8'h00);
    $display("test irq done");
    wr(OFF_PORTA_DIR, 8'h00);
    wr(OFF_CMP_CTRL, 8'h13);
    repeat (8) @(posedge clk);
    chk(32'(port_a_oe_n), 32'h0);
    chk(32'(port_a_out[5:4]), 32'h2);
    rd(OFF_CMP_RAW, 8'h03);
    wr(OFF_CMP_CTRL, 8'h07);
    wr(OFF_PORTA_LAT, 8'ha5);
    @(posedge clk);
    chk(32'(port_a_out), 32'ha5);
    wr(OFF_CONV_CFG1, 8'h0c);
    rd(OFF_PORTA_DATA, 8'hf8);
    wr(OFF_CONV_CFG1, 8'h0f);
    rd(OFF_PORTA_DATA, 8'hff);
    $display("test pins done");
    xfer(1'b0, 8'h28, 32'h0);
    chk({31'h0, se}, 32'h1);
    chk(q, 32'h0);
    $display("test unmapped done");
    // reset in mid-run must bring the mode back to off
    wr(OFF_CMP_CTRL, 8'h02);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rd(OFF_CMP_CTRL, 8'h07);
    chk(32'(cmp_active), 32'h0);
    $display("test second reset done");
    conclude();
  end
endmodule
